/* inc/dlims_map.svh */
// register offsets, field positions and reset values of the interrupt mask block
`ifndef DLIMS_MAP_SVH
`define DLIMS_MAP_SVH

// register byte addresses on the wishbone bus
`define DLIMS_NORMAL_STATUS_ADR     32'hFFFF0000
`define DLIMS_NORMAL_RAW_ADR        32'hFFFF0004
`define DLIMS_NORMAL_ENABLE_ADR     32'hFFFF0008
`define DLIMS_NORMAL_CLEAR_ADR      32'hFFFF000C
`define DLIMS_FAST_STATUS_ADR       32'hFFFF0100
`define DLIMS_FAST_RAW_ADR          32'hFFFF0104
`define DLIMS_FAST_ENABLE_ADR       32'hFFFF0108
`define DLIMS_FAST_CLEAR_ADR        32'hFFFF010C
`define DLIMS_NESTING_CONTROL_ADR   32'hFFFF0030
`define DLIMS_SW_TRIGGER_ADR        32'hFFFF0034

// source bit positions
`define DLIMS_BIT_COMBINED_FAST     0
`define DLIMS_BIT_SOFTWARE          1
`define DLIMS_BIT_TIMER0            3
`define DLIMS_BIT_TIMER1_WAKE       4
`define DLIMS_BIT_TIMER2_WDOG       5
`define DLIMS_BIT_TIMER3            6
`define DLIMS_BIT_CONVERTER         10
`define DLIMS_BIT_UART              11
`define DLIMS_BIT_SPI               12
`define DLIMS_BIT_EXT_PIN_INT0      13
`define DLIMS_BIT_EXT_PIN_INT1      14
`define DLIMS_BIT_I2C_MASTER        15
`define DLIMS_BIT_I2C_SLAVE         16
`define DLIMS_BIT_PWM_TRIP          17
`define DLIMS_BIT_EXT_PIN_INT2      18
`define DLIMS_BIT_EXT_PIN_INT3      19

// implemented source positions, and those fed by peripheral lines
`define DLIMS_SRC_VALID_MASK        32'h000FFC7B
`define DLIMS_SRC_PERIPH_MASK       32'h000FFC78

// nesting control and software trigger fields
`define DLIMS_NEST_NORMAL_BIT       0
`define DLIMS_NEST_FAST_BIT         1
`define DLIMS_SWT_NORMAL_BIT        1
`define DLIMS_SWT_FAST_BIT          2

// reset value of every register
`define DLIMS_RESET_WORD            32'h00000000

`endif

/* inc/dlims_pkg.sv */
// types shared by the interrupt mask block
package dlims_pkg;

    typedef logic [31:0] dlims_word_t;

    // register selected by the bus address
    typedef enum logic [3:0]
    {
        SEL_NONE,
        SEL_N_STA,
        SEL_N_RAW,
        SEL_N_EN,
        SEL_N_CLR,
        SEL_F_STA,
        SEL_F_RAW,
        SEL_F_EN,
        SEL_F_CLR,
        SEL_NEST,
        SEL_SWT
    } dlims_sel_t;

    // state of the top: bus answer, requests and control bits
    typedef struct packed
    {
        logic        ack;
        dlims_word_t rdata;
        logic        irq;
        logic        fast_request;
        logic [1:0]  nest;
        logic [1:0]  swt;
    } dlims_top_state_t;

    // state of one request level
    typedef struct packed
    {
        dlims_word_t raw;
        dlims_word_t en;
    } dlims_level_state_t;

endpackage : dlims_pkg

/* src/dlims_level.sv */
// one request level: raw flags, enable mask and masked status
`timescale 1ns/10ps
`default_nettype none
`include "dlims_map.svh"

module dlims_level
(
    input  wire logic               clk_i,        // system clock
    input  wire logic               rst_i,        // synchronous reset, high
    input  wire dlims_pkg::dlims_word_t periph_i, // peripheral request lines
    input  wire logic               sw_req_i,     // software trigger for this level
    input  wire logic               combined_i,   // combined fast request
    input  wire dlims_pkg::dlims_word_t en_set_i, // enable bits to set
    input  wire dlims_pkg::dlims_word_t en_clr_i, // enable bits to clear
    output logic [31:0]             raw_o,        // raw flags as read
    output logic [31:0]             en_o,         // enable mask as read
    output logic [31:0]             status_o,     // masked status as read
    output logic                    any_hi_o,     // or of status 31..1
    output logic                    any_all_o     // or of all status bits
);
    import dlims_pkg::*;

    dlims_level_state_t state_reg;  // registered state
    dlims_level_state_t state_next; // next state
    logic [31:0]        hi_view;    // status without the combined bit 0

    // next state: raw follows the lines, enables are set or cleared only
    always_comb
    begin
        state_next = state_reg;
        // raw tracks the peripheral line, no latching
        state_next.raw = periph_i & `DLIMS_SRC_PERIPH_MASK;
        // clear first, set wins inside the same access
        state_next.en = ((state_reg.en & ~en_clr_i) | en_set_i)
                        & `DLIMS_SRC_VALID_MASK;
    end

    // state register, zero after reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '{default: '0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // read views; software bit bypasses the mask
    always_comb
    begin
        raw_o = state_reg.raw;
        raw_o[`DLIMS_BIT_SOFTWARE] = sw_req_i;
        raw_o[`DLIMS_BIT_COMBINED_FAST] = combined_i;
        en_o = state_reg.en;
        status_o = raw_o & state_reg.en;
        status_o[`DLIMS_BIT_SOFTWARE] = sw_req_i;
        any_all_o = |status_o;
    end

    // fast-request term built from registers only, so the combined bit 0
    // fed back into this level never closes a loop through this process
    always_comb
    begin
        hi_view = state_reg.raw & state_reg.en;
        hi_view[`DLIMS_BIT_SOFTWARE] = sw_req_i;
        any_hi_o = |hi_view[31:1];
    end

endmodule : dlims_level
`default_nettype wire

/* src/dlims_top.sv */
// dual level interrupt mask and status block with a wishbone slave
//
// Function
// - bits 1,3-6 software and timers; 2,7-9 unused
// - bits 10-19 converter, serial, pins, pwm
// - fast bit 0 is combined fast request
// - raw flag follows peripheral request line
// - enable one passes source, zero masks it
// - writing zero to enable clears nothing
// - clear register ones clear enable bits
// - status is raw AND enable
// - normal request is OR of status
// - no priority encoder, software reads status
// - fast level mirrors normal level registers
// - fast request ORs fast status 31..1
// - fast enable set clears normal enable
// - normal enable set clears fast enable
// - source may be disabled on both levels
// - every source except software bit 1 maskable on each level
// - nesting usable only after nesting enable
// - nesting bit 0 normal, bit 1 fast
// - software trigger drives raw and status bit 1
`timescale 1ns/10ps
`default_nettype none
`include "dlims_map.svh"

module dlims_top
(
    input  wire logic                   clk_i,          // 20 MHz system clock
    input  wire logic                   rst_i,          // synchronous reset, high
    input  wire logic                   wb_cyc_i,       // bus cycle
    input  wire logic                   wb_stb_i,       // bus strobe
    input  wire logic                   wb_we_i,        // write enable
    input  wire dlims_pkg::dlims_word_t wb_adr_i,       // byte address
    input  wire logic [3:0]             wb_sel_i,       // byte lanes
    input  wire dlims_pkg::dlims_word_t wb_dat_i,       // write data
    output logic [31:0]                 wb_dat_o,       // read data
    output logic                        wb_ack_o,       // answer
    input  wire dlims_pkg::dlims_word_t periph_req_i,   // request lines by bit
    output logic                        irq_o,          // normal request
    output logic                        fiq_o,          // fast request
    output logic [1:0]                  nesting_enable_o // nesting enables
);
    import dlims_pkg::*;

    // registered state of the whole top
    dlims_top_state_t state_reg;
    // next value of that state
    dlims_top_state_t state_next;

    // register selected by the current address
    dlims_sel_t       sel;
    // byte lanes expanded to a bit mask for the write data
    dlims_word_t      lane_mask;
    // write data after lane and valid masking
    dlims_word_t      wdata;
    // write takes effect in this cycle
    logic             wr_fire;
    // request seen and not yet answered
    logic             rd_take;

    // enable set and clear vectors for both levels
    dlims_word_t      n_set;
    dlims_word_t      n_clr;
    dlims_word_t      f_set;
    dlims_word_t      f_clr;

    // read views of both levels
    logic [31:0]      n_raw;
    logic [31:0]      n_en;
    logic [31:0]      n_sta;
    logic [31:0]      f_raw;
    logic [31:0]      f_en;
    logic [31:0]      f_sta;

    // request terms from both levels
    logic             n_any_all;
    logic             f_any_hi;

    // read word chosen by the address
    dlims_word_t      rd_word;

    // byte lanes expanded to bit masks, one lane per pass
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            assign lane_mask[8*g +: 8] = {8{wb_sel_i[g]}};
        end
    endgenerate

    // address decode; anything else is unmapped and reads zero
    always_comb
    begin
        unique case (wb_adr_i)
            `DLIMS_NORMAL_STATUS_ADR:
            begin
                sel = SEL_N_STA;
            end
            `DLIMS_NORMAL_RAW_ADR:
            begin
                sel = SEL_N_RAW;
            end
            `DLIMS_NORMAL_ENABLE_ADR:
            begin
                sel = SEL_N_EN;
            end
            `DLIMS_NORMAL_CLEAR_ADR:
            begin
                sel = SEL_N_CLR;
            end
            `DLIMS_FAST_STATUS_ADR:
            begin
                sel = SEL_F_STA;
            end
            `DLIMS_FAST_RAW_ADR:
            begin
                sel = SEL_F_RAW;
            end
            `DLIMS_FAST_ENABLE_ADR:
            begin
                sel = SEL_F_EN;
            end
            `DLIMS_FAST_CLEAR_ADR:
            begin
                sel = SEL_F_CLR;
            end
            `DLIMS_NESTING_CONTROL_ADR:
            begin
                sel = SEL_NEST;
            end
            `DLIMS_SW_TRIGGER_ADR:
            begin
                sel = SEL_SWT;
            end
            // every other address is a legal code, so a default is needed
            default:
            begin
                sel = SEL_NONE;
            end
        endcase
    end

    // bus handshake terms
    always_comb
    begin
        // a new request gets its ack one cycle later
        rd_take = wb_cyc_i & wb_stb_i & ~state_reg.ack;
        // writes land on the edge where the master samples ack
        wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & state_reg.ack;
        // masked write data; unused positions never reach the masks
        wdata = wb_dat_i & lane_mask & `DLIMS_SRC_VALID_MASK;
    end

    // enable side effects of each write
    always_comb
    begin
        n_set = '0;
        n_clr = '0;
        f_set = '0;
        f_clr = '0;
        if (wr_fire)
        begin
            unique case (sel)
                SEL_N_EN:
                begin
                    // zeros in the data leave enables alone
                    n_set = wdata;
                    // the same bit leaves the fast mask
                    f_clr = wdata;
                end
                SEL_F_EN:
                begin
                    // fast mirrors the normal set
                    f_set = wdata;
                    // the same bit leaves the normal mask
                    n_clr = wdata;
                end
                SEL_N_CLR:
                begin
                    // only ones clear, others unchanged
                    n_clr = wdata;
                end
                SEL_F_CLR:
                begin
                    // fast clear mirrors the normal one
                    f_clr = wdata;
                end
                // status, raw and control registers touch no enable
                SEL_NONE, SEL_N_STA, SEL_N_RAW, SEL_F_STA, SEL_F_RAW,
                SEL_NEST, SEL_SWT:
                begin
                    n_set = '0;
                end
            endcase
        end
    end

    // normal level; bit 0 shows the combined fast request
    dlims_level u_normal
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .periph_i   (periph_req_i),
        .sw_req_i   (state_reg.swt[0]),
        .combined_i (f_any_hi),
        .en_set_i   (n_set),
        .en_clr_i   (n_clr),
        .raw_o      (n_raw),
        .en_o       (n_en),
        .status_o   (n_sta),
        .any_hi_o   (),
        .any_all_o  (n_any_all)
    );

    // fast level, identical logic on the same request lines
    dlims_level u_fast
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .periph_i   (periph_req_i),
        .sw_req_i   (state_reg.swt[1]),
        .combined_i (f_any_hi),
        .en_set_i   (f_set),
        .en_clr_i   (f_clr),
        .raw_o      (f_raw),
        .en_o       (f_en),
        .status_o   (f_sta),
        .any_hi_o   (f_any_hi),
        .any_all_o  ()
    );

    // read multiplexer; software finds the source here itself
    always_comb
    begin
        rd_word = `DLIMS_RESET_WORD;
        unique case (sel)
            SEL_N_STA:
            begin
                rd_word = n_sta;
            end
            SEL_N_RAW:
            begin
                rd_word = n_raw;
            end
            SEL_N_EN:
            begin
                rd_word = n_en;
            end
            SEL_F_STA:
            begin
                rd_word = f_sta;
            end
            SEL_F_RAW:
            begin
                rd_word = f_raw;
            end
            SEL_F_EN:
            begin
                rd_word = f_en;
            end
            SEL_NEST:
            begin
                rd_word[`DLIMS_NEST_NORMAL_BIT] = state_reg.nest[0];
                rd_word[`DLIMS_NEST_FAST_BIT] = state_reg.nest[1];
            end
            SEL_SWT:
            begin
                rd_word[`DLIMS_SWT_NORMAL_BIT] = state_reg.swt[0];
                rd_word[`DLIMS_SWT_FAST_BIT] = state_reg.swt[1];
            end
            // clear registers are write only and unmapped reads zero
            SEL_N_CLR, SEL_F_CLR, SEL_NONE:
            begin
                rd_word = `DLIMS_RESET_WORD;
            end
        endcase
    end

    // next state of the top
    always_comb
    begin
        state_next = state_reg;
        // ack is a single cycle pulse, dropped the cycle after
        state_next.ack = rd_take;
        // read data is caught with the ack so it stands beside it
        if (rd_take)
        begin
            state_next.rdata = rd_word;
        end
        else
        begin
            state_next.rdata = `DLIMS_RESET_WORD;
        end
        // nesting enables per level, only a gate for the vector unit
        if (wr_fire && sel == SEL_NEST && wb_sel_i[0])
        begin
            state_next.nest[0] = wb_dat_i[`DLIMS_NEST_NORMAL_BIT];
            state_next.nest[1] = wb_dat_i[`DLIMS_NEST_FAST_BIT];
        end
        // software trigger bits; set and cleared only by software
        if (wr_fire && sel == SEL_SWT && wb_sel_i[0])
        begin
            state_next.swt[0] = wb_dat_i[`DLIMS_SWT_NORMAL_BIT];
            state_next.swt[1] = wb_dat_i[`DLIMS_SWT_FAST_BIT];
        end
        // requests registered so the core sees a clean level
        state_next.irq = n_any_all;
        // fast request leaves bit 0 out to avoid feeding itself
        state_next.fast_request = f_any_hi;
    end

    // single state register; reset is synchronous to the clock
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '{default: '0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs come straight from the state register
    always_comb
    begin
        wb_ack_o = state_reg.ack;
        wb_dat_o = state_reg.rdata;
        irq_o = state_reg.irq;
        fiq_o = state_reg.fast_request;
        nesting_enable_o = state_reg.nest;
    end

    // the normal 31..1 term and the fast all-bits term are left open:
    // the fast request must leave bit 0 out, or it would feed itself

endmodule : dlims_top
`default_nettype wire

/* bench/dlims_props.sv */
// port checks of the interrupt mask block, bound onto its top
`timescale 1ns/10ps
`default_nettype none
`include "dlims_map.svh"

module dlims_props
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire dlims_pkg::dlims_word_t wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire dlims_pkg::dlims_word_t wb_dat_i,
    input  wire logic [31:0]            wb_dat_o,
    input  wire logic                   wb_ack_o,
    input  wire dlims_pkg::dlims_word_t periph_req_i,
    input  wire logic                   irq_o,
    input  wire logic                   fiq_o,
    input  wire logic [1:0]             nesting_enable_o
);
    import dlims_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_ack;   // read answer in this cycle
    logic nest_wr;  // nesting write that lands on this edge
    logic lvl_reg;  // address of a level register
    assign rd_ack  = wb_ack_o && !wb_we_i;
    assign nest_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == `DLIMS_NESTING_CONTROL_ADR;
    assign lvl_reg = wb_adr_i[31:16] == 16'hFFFF && wb_adr_i[3:0] != 4'hC
                     && (wb_adr_i[15:4] == 12'h000 || wb_adr_i[15:4] == 12'h010);
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer longer than one cycle");
    chk_ack_delay: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus answer late");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data outside answer");
    chk_reset_out: assert property ($past(rst_i) |-> !irq_o && !fiq_o && !wb_ack_o
        && nesting_enable_o == 2'h0)
        else $error("outputs not clear after reset");
    chk_clr_reads: assert property (rd_ack && (wb_adr_i == `DLIMS_NORMAL_CLEAR_ADR
        || wb_adr_i == `DLIMS_FAST_CLEAR_ADR) |-> wb_dat_o == 32'h00000000)
        else $error("clear register read not zero");
    chk_unused_zero: assert property (rd_ack && lvl_reg
        |-> (wb_dat_o & ~`DLIMS_SRC_VALID_MASK) == 32'h00000000)
        else $error("unused source bit read as one");
    chk_nest_write: assert property (nest_wr |=> nesting_enable_o == $past(wb_dat_i[1:0]))
        else $error("nesting enables not written");
    chk_nest_hold: assert property (!nest_wr |=> $stable(nesting_enable_o))
        else $error("nesting enables changed without write");
    chk_fiq_cause: assert property ($rose(fiq_o) |-> $past(wb_ack_o && wb_we_i, 2)
        || $past(periph_req_i, 2) != $past(periph_req_i, 3) || $past(rst_i, 3))
        else $error("fast request rose without cause");
    chk_irq_cause: assert property ($rose(irq_o) |-> $past(wb_ack_o && wb_we_i, 2)
        || $past(wb_ack_o && wb_we_i, 3) || $past(rst_i, 4)
        || $past(periph_req_i, 2) != $past(periph_req_i, 3))
        else $error("normal request rose without cause");
endmodule : dlims_props

bind dlims_top dlims_props props_i (.*);
`default_nettype wire

/* bench/dlims_core_model.sv */
// processor core model: counts entries into normal and fast handling
`timescale 1ns/10ps
`default_nettype none

module dlims_core_model
(
    input  wire logic  clk_i,          // system clock
    input  wire logic  rst_i,          // synchronous reset, high
    input  wire logic  irq_i,          // normal request
    input  wire logic  fiq_i,          // fast request
    output logic [7:0] irq_entries_o,  // normal handler entries
    output logic [7:0] fiq_entries_o   // fast handler entries
);
    typedef struct packed
    {
        logic       irq_d;
        logic       fiq_d;
        logic [7:0] ni;
        logic [7:0] nf;
    } dlims_core_state_t;
    dlims_core_state_t state_reg;   // registered state
    dlims_core_state_t state_next;  // its next value
    // a level request enters the handler once per rising edge; the
    // counts are eight bits wide and wrap after 255
    always_comb
    begin
        state_next = state_reg;
        state_next.irq_d = irq_i;
        state_next.fiq_d = fiq_i;
        if (irq_i && !state_reg.irq_d)  // entry on normal level
            state_next.ni = state_reg.ni + 8'h01;
        if (fiq_i && !state_reg.fiq_d)  // entry on fast level
            state_next.nf = state_reg.nf + 8'h01;
    end
    // register the state, cleared by reset
    always_ff @(posedge clk_i)
        state_reg <= rst_i ? '0 : state_next;
    assign irq_entries_o = state_reg.ni;
    assign fiq_entries_o = state_reg.nf;
endmodule : dlims_core_model
`default_nettype wire

/* bench/dlims_top_test.sv */
// self-checking register bench of the interrupt mask block
`timescale 1ns/10ps
`default_nettype none
`include "dlims_map.svh"

module dlims_top_test;
    import dlims_pkg::*;
    logic        clk_i  = 1'b0;
    logic        rst_i  = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we  = 1'b0;
    dlims_word_t wb_adr = 32'h0;
    logic [3:0]  wb_sel = 4'h0;
    dlims_word_t wb_dw  = 32'h0;
    logic [31:0] wb_dr;
    logic        wb_ack;
    dlims_word_t periph = 32'h0;
    logic        irq;
    logic        fast_request;
    logic [1:0]  nest;
    logic [7:0]  irq_n;
    logic [7:0]  fiq_n;
    int          errors = 0;
    int          num_checks = 0;
    dlims_word_t m;
    dlims_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dw),
        .wb_dat_o(wb_dr), .wb_ack_o(wb_ack), .periph_req_i(periph), .irq_o(irq),
        .fiq_o(fast_request), .nesting_enable_o(nest));
    dlims_core_model core (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .fiq_i(fast_request),
        .irq_entries_o(irq_n), .fiq_entries_o(fiq_n));
    // 20 MHz clock
    initial
        forever #25 clk_i = ~clk_i;
    task conclude;
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // one classic cycle; the wait for the answer is bounded
    task xfer(input logic we, input dlims_word_t adr, input dlims_word_t dat,
              input logic [3:0] sel, output dlims_word_t rd);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dw  <= dat;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 20);
        rd = wb_dr;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (wb_ack !== 1'b1)
        begin
            errors++;
            conclude();
        end
    endtask : xfer
    task wr(input dlims_word_t adr, input dlims_word_t dat, input logic [3:0] sel = 4'hF);
        dlims_word_t d;
        xfer(1'b1, adr, dat, sel, d);
    endtask : wr
    task rd_chk(input string name, input dlims_word_t adr, input dlims_word_t exp);
        dlims_word_t d;
        xfer(1'b0, adr, 32'h0, 4'hF, d);
        check(name, exp, d);
    endtask : rd_chk
    dlims_word_t regs [8] = '{`DLIMS_NORMAL_STATUS_ADR, `DLIMS_NORMAL_RAW_ADR,
        `DLIMS_NORMAL_ENABLE_ADR, `DLIMS_NORMAL_CLEAR_ADR, `DLIMS_FAST_STATUS_ADR,
        `DLIMS_FAST_RAW_ADR, `DLIMS_FAST_ENABLE_ADR, `DLIMS_FAST_CLEAR_ADR};
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (regs[i])
            rd_chk("reset value", regs[i], 32'h0);
        rd_chk("unmapped", 32'hFFFF0200, 32'h0);
        // enable sets, zero keeps, clear removes
        wr(`DLIMS_NORMAL_ENABLE_ADR, 32'hFFFFFFFF);
        rd_chk("n_en", `DLIMS_NORMAL_ENABLE_ADR, 32'h000FFC7B);
        wr(`DLIMS_NORMAL_ENABLE_ADR, 32'h0);
        rd_chk("n_en", `DLIMS_NORMAL_ENABLE_ADR, 32'h000FFC7B);
        wr(`DLIMS_NORMAL_CLEAR_ADR, 32'h8);
        rd_chk("n_en", `DLIMS_NORMAL_ENABLE_ADR, 32'h000FFC73);
        // cross-mask side effects, then both levels off
        wr(`DLIMS_FAST_ENABLE_ADR, 32'h10);
        rd_chk("f_en", `DLIMS_FAST_ENABLE_ADR, 32'h10);
        rd_chk("n_en", `DLIMS_NORMAL_ENABLE_ADR, 32'h000FFC63);
        wr(`DLIMS_NORMAL_ENABLE_ADR, 32'h10);
        rd_chk("f_en", `DLIMS_FAST_ENABLE_ADR, 32'h0);
        wr(`DLIMS_NORMAL_CLEAR_ADR, 32'hFFFFFFFF);
        rd_chk("n_en", `DLIMS_NORMAL_ENABLE_ADR, 32'h0);
        wr(`DLIMS_NORMAL_ENABLE_ADR, 32'hFFFFFFFF, 4'h2);
        rd_chk("n_en lane", `DLIMS_NORMAL_ENABLE_ADR, 32'h0000FC00);
        wr(`DLIMS_NORMAL_CLEAR_ADR, 32'hFFFFFFFF);
        wr(`DLIMS_NORMAL_RAW_ADR, 32'hFFFFFFFF);
        rd_chk("n_raw", `DLIMS_NORMAL_RAW_ADR, 32'h0);
        // every peripheral position on normal, then moved to fast
        for (int b = 0; b < 32; b++)
        begin
            m = 32'h1 << b;
            if ((m & 32'h000FFC78) != 0)
            begin
                wr(`DLIMS_NORMAL_ENABLE_ADR, m);
                periph <= m;
                repeat (3) @(posedge clk_i);
                check("irq_o", 32'h1, 32'(irq));
                rd_chk("n_raw", `DLIMS_NORMAL_RAW_ADR, m);
                rd_chk("n_sta", `DLIMS_NORMAL_STATUS_ADR, m);
                wr(`DLIMS_FAST_ENABLE_ADR, m);
                repeat (3) @(posedge clk_i);
                check("fiq_o", 32'h1, 32'(fast_request));
                check("irq_o", 32'h0, 32'(irq));
                rd_chk("f_sta", `DLIMS_FAST_STATUS_ADR, m);
                rd_chk("n_raw", `DLIMS_NORMAL_RAW_ADR, m | 32'h1);
                wr(`DLIMS_FAST_CLEAR_ADR, m);
                periph <= 32'h0;
                repeat (3) @(posedge clk_i);
                check("fiq_o", 32'h0, 32'(fast_request));
            end
        end
        // software source bypasses the masks
        wr(`DLIMS_SW_TRIGGER_ADR, 32'h2);
        repeat (2) @(posedge clk_i);
        check("irq_o", 32'h1, 32'(irq));
        rd_chk("n_sta", `DLIMS_NORMAL_STATUS_ADR, 32'h2);
        wr(`DLIMS_SW_TRIGGER_ADR, 32'h4);
        repeat (2) @(posedge clk_i);
        check("fiq_o", 32'h1, 32'(fast_request));
        rd_chk("f_raw", `DLIMS_FAST_RAW_ADR, 32'h3);
        rd_chk("n_raw", `DLIMS_NORMAL_RAW_ADR, 32'h1);
        wr(`DLIMS_NORMAL_ENABLE_ADR, 32'h1);
        rd_chk("n_sta bit0", `DLIMS_NORMAL_STATUS_ADR, 32'h1);
        check("irq_o bit0", 32'h1, 32'(irq));
        wr(`DLIMS_SW_TRIGGER_ADR, 32'h0);
        repeat (2) @(posedge clk_i);
        check("fiq_o", 32'h0, 32'(fast_request));
        // nesting enables, lane 0 needed
        wr(`DLIMS_NESTING_CONTROL_ADR, 32'h3);
        @(posedge clk_i);
        check("nest", 32'h3, 32'(nest));
        wr(`DLIMS_NESTING_CONTROL_ADR, 32'h0, 4'hE);
        @(posedge clk_i);
        check("nest", 32'h3, 32'(nest));
        wr(`DLIMS_NESTING_CONTROL_ADR, 32'h2);
        @(posedge clk_i);
        check("nest", 32'h2, 32'(nest));
        check("irq entries", 32'd16, 32'(irq_n));
        check("fiq entries", 32'd15, 32'(fiq_n));
        conclude();
    end
endmodule : dlims_top_test
`default_nettype wire
